// ===== design/adcc_consts.svh
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// System clock rate in MHz
`define ADCC_CLK_MHZ 50

// Default busy durations in ns
`define ADCC_BUSY_NS 1000
`define ADCC_BUSY_RAC_NS 1500

// Configuration register width and field positions
`define ADCC_CFG_W 5
`define ADCC_CFG_WIDE 0
`define ADCC_CFG_BIPOLAR 1
`define ADCC_CFG_MS 2
`define ADCC_CFG_RDC 3
`define ADCC_CFG_BINFMT 4
`define ADCC_CFG_RST 5'h00

// Data width and reset value of the result
`define ADCC_DATA_W 16
`define ADCC_DATA_RST 16'h0000

// Positions in the synchroniser vector
`define ADCC_NSYNC 16
`define ADCC_S_RESET 0
`define ADCC_S_CONV 1
`define ADCC_S_CS 2
`define ADCC_S_RD 3
`define ADCC_S_SDI 4
`define ADCC_S_SCLK 5
`define ADCC_S_SCS 6
`define ADCC_S_SERCLK 7
`define ADCC_S_SRC 8
`define ADCC_S_SERPAR 9
`define ADCC_S_MS 10
`define ADCC_S_RDC 11
`define ADCC_S_WIDE 12
`define ADCC_S_BIP 13
`define ADCC_S_BINFMT 14
`define ADCC_S_INV 15

// Synchroniser reset value: active-low selects start at their idle high level
`define ADCC_SYNC_IDLE 16'h004c

`endif

// ===== design/adcc_pkg.sv
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_UNI_5 = 2'b00,
    ADCC_UNI_10 = 2'b01,
    ADCC_BIP_5 = 2'b10,
    ADCC_BIP_10 = 2'b11
  } adcc_range_t;

  typedef enum logic [0:0] {
    ADCC_IDLE = 1'b0,
    ADCC_CONV = 1'b1
  } adcc_state_t;

  typedef struct packed {
    logic binary_format_sel;
    logic read_during_convert_sel;
    logic master_slave_select;
    logic bipolar_sel;
    logic wide_range_sel;
  } adcc_cfg_t;

endpackage : adcc_pkg

// ===== design/adcc_top.sv
// Summary of operation
// - Source select low: range and mode come from serial configuration register.
// - Source select high: range and mode come straight from hardware pins.
// - Serial config bits shift in MSB first, one per config clock edge.
// - Clock-edge invert pin picks which config clock edge samples data.
// - Config chip select enables the serial config port around each write.
// - In parallel mode the config pins drive data bits 13, 14, 15.
// - Busy rises at conversion start, falls on the same clock edge that loads the result into the shift register.
// - Master read-after-convert mode uses a different busy duration.
// - Unipolar ranges: wide low gives 0-5 V, wide high 0-10 V.
// - Bipolar ranges: wide low gives +-5 V, wide high +-10 V.
// - Output bus enabled only while chip select and read both low.
// - Slave serial clock is gated by chip select, not config port.
// - Reset pin high holds device in reset, aborting any conversion.
// - Reset falling edge clears data outputs and configuration register.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"

module adcc_top
  import adcc_pkg::*;
#(
  parameter int BUSY_NS = `ADCC_BUSY_NS,
  parameter int BUSY_RAC_NS = `ADCC_BUSY_RAC_NS
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Device reset pin and conversion start
  input wire logic RESET_IN,
  input wire logic CONV_START,
  input wire logic [`ADCC_DATA_W-1:0] CONV_RESULT,
  // Hardware configuration pins
  input wire logic CFG_SOURCE_SELECT,
  input wire logic SERIAL_PARALLEL_SELECT,
  input wire logic MASTER_SLAVE_SELECT,
  input wire logic READ_DURING_CONVERT_SEL,
  input wire logic WIDE_RANGE_SEL,
  input wire logic BIPOLAR_SEL,
  input wire logic BINARY_FORMAT_SEL,
  input wire logic CLK_EDGE_INVERT,
  // Shared pins: data bit 13 or config serial data
  input wire logic D13_I,
  output logic D13_O,
  output logic D13_OE,
  // Shared pins: data bit 14 or config serial clock
  input wire logic D14_I,
  output logic D14_O,
  output logic D14_OE,
  // Shared pins: data bit 15 or config chip select
  input wire logic D15_I,
  output logic D15_O,
  output logic D15_OE,
  // Host read interface
  input wire logic CS_B,
  input wire logic RD_B,
  input wire logic SER_CLK_IN,
  output logic [12:0] PAR_DATA_O,
  output logic PAR_DATA_OE,
  output logic SER_DATA_O,
  output logic SER_DATA_OE,
  // Status and effective settings
  output logic BUSY,
  output adcc_cfg_t EFF_CFG,
  output adcc_range_t RANGE_SEL,
  output adcc_cfg_t CFG_REG
);

  localparam logic [15:0] BUSY_CYC =
    16'((BUSY_NS * `ADCC_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] BUSY_RAC_CYC =
    16'((BUSY_RAC_NS * `ADCC_CLK_MHZ + 999) / 1000);

  logic [`ADCC_NSYNC-1:0] pin_vec;
  logic [`ADCC_NSYNC-1:0] meta_ff;
  logic [`ADCC_NSYNC-1:0] sync_ff;
  logic [`ADCC_NSYNC-1:0] prev_ff;
  adcc_state_t state_ff;
  logic [15:0] cnt_ff;
  logic [`ADCC_DATA_W-1:0] sh_ff;
  adcc_cfg_t cfg_ff;
  logic [`ADCC_CFG_W-1:0] cfg_shift_ff;
  logic [7:0] cfg_cnt_ff;
  logic busy_ff;
  logic ser_out_ff;
  adcc_cfg_t hw_cfg;
  adcc_cfg_t eff;
  logic dev_rst;
  logic rst_fall;
  logic conv_rise;
  logic serial_mode;
  logic sw_cfg_mode;
  logic cfg_cs_b;
  logic cfg_edge;
  logic cfg_end;
  logic ser_edge;
  logic bus_en;
  logic rac_mode;
  logic [`ADCC_DATA_W-1:0] fmt_result;

  function automatic logic rise(input logic now_v, input logic old_v);
    rise = now_v & ~old_v;
  endfunction : rise

  assign pin_vec = {CLK_EDGE_INVERT, BINARY_FORMAT_SEL, BIPOLAR_SEL, WIDE_RANGE_SEL,
                    READ_DURING_CONVERT_SEL, MASTER_SLAVE_SELECT, SERIAL_PARALLEL_SELECT,
                    CFG_SOURCE_SELECT, SER_CLK_IN, D15_I, D14_I, D13_I, RD_B, CS_B,
                    CONV_START, RESET_IN};

  // Two-stage synchronisers plus one stage for edge detection
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      meta_ff <= `ADCC_SYNC_IDLE;
      sync_ff <= `ADCC_SYNC_IDLE;
      prev_ff <= `ADCC_SYNC_IDLE;
    end else begin
      meta_ff <= pin_vec;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign dev_rst = sync_ff[`ADCC_S_RESET];
  assign rst_fall = rise(prev_ff[`ADCC_S_RESET], sync_ff[`ADCC_S_RESET]);
  assign conv_rise = rise(sync_ff[`ADCC_S_CONV], prev_ff[`ADCC_S_CONV]);
  assign serial_mode = sync_ff[`ADCC_S_SERPAR];
  assign sw_cfg_mode = serial_mode & ~sync_ff[`ADCC_S_SRC];
  assign cfg_cs_b = sync_ff[`ADCC_S_SCS];

  // Selected config clock edge: rising when invert low, falling when high
  assign cfg_edge = sync_ff[`ADCC_S_INV] ?
                    rise(prev_ff[`ADCC_S_SCLK], sync_ff[`ADCC_S_SCLK]) :
                    rise(sync_ff[`ADCC_S_SCLK], prev_ff[`ADCC_S_SCLK]);
  assign cfg_end = rise(sync_ff[`ADCC_S_SCS], prev_ff[`ADCC_S_SCS]);

  // Serial configuration shifter, MSB first, only while enabled
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cfg_shift_ff <= `ADCC_CFG_RST;
      cfg_cnt_ff <= 8'h00;
    end else if (!sw_cfg_mode || cfg_end) begin
      cfg_cnt_ff <= 8'h00;
    end else if (!cfg_cs_b && cfg_edge) begin
      cfg_shift_ff <= {cfg_shift_ff[`ADCC_CFG_W-2:0], sync_ff[`ADCC_S_SDI]};
      if (cfg_cnt_ff != 8'hff) begin
        cfg_cnt_ff <= cfg_cnt_ff + 8'h01;
      end
    end
  end

  // Configuration register: committed at end of a complete write
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cfg_ff <= `ADCC_CFG_RST;
    end else if (rst_fall) begin
      cfg_ff <= `ADCC_CFG_RST;
    end else if (sw_cfg_mode && cfg_end && cfg_cnt_ff >= 8'(`ADCC_CFG_W)) begin
      cfg_ff <= cfg_shift_ff;
    end
  end

  assign hw_cfg.binary_format_sel = sync_ff[`ADCC_S_BINFMT];
  assign hw_cfg.read_during_convert_sel = sync_ff[`ADCC_S_RDC];
  assign hw_cfg.master_slave_select = sync_ff[`ADCC_S_MS];
  assign hw_cfg.bipolar_sel = sync_ff[`ADCC_S_BIP];
  assign hw_cfg.wide_range_sel = sync_ff[`ADCC_S_WIDE];
  assign eff = sync_ff[`ADCC_S_SRC] ? hw_cfg : cfg_ff;

  assign rac_mode = serial_mode & ~eff.master_slave_select &
                    ~eff.read_during_convert_sel;
  assign fmt_result = eff.binary_format_sel ? CONV_RESULT :
                      {~CONV_RESULT[`ADCC_DATA_W-1], CONV_RESULT[`ADCC_DATA_W-2:0]};

  // Conversion sequencing and busy
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= ADCC_IDLE;
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
    end else if (dev_rst) begin
      state_ff <= ADCC_IDLE;
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
    end else begin
      case (state_ff)
        ADCC_IDLE: begin
          if (conv_rise) begin
            state_ff <= ADCC_CONV;
            busy_ff <= 1'b1;
            cnt_ff <= rac_mode ? BUSY_RAC_CYC : BUSY_CYC;
          end
        end
        ADCC_CONV: begin
          if (cnt_ff <= 16'h0001) begin
            state_ff <= ADCC_IDLE;
            busy_ff <= 1'b0;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: begin
          state_ff <= ADCC_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // Slave serial clock counts only while chip select low
  assign ser_edge = serial_mode & eff.master_slave_select & ~sync_ff[`ADCC_S_CS] &
                    rise(sync_ff[`ADCC_S_SERCLK], prev_ff[`ADCC_S_SERCLK]);

  // Output shift register: loaded at conversion end, shifted by slave clock
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sh_ff <= `ADCC_DATA_RST;
      ser_out_ff <= 1'b0;
    end else if (rst_fall) begin
      sh_ff <= `ADCC_DATA_RST;
      ser_out_ff <= 1'b0;
    end else if (!dev_rst && state_ff == ADCC_CONV && cnt_ff <= 16'h0001) begin
      sh_ff <= fmt_result;
      ser_out_ff <= fmt_result[`ADCC_DATA_W-1];
    end else if (ser_edge) begin
      sh_ff <= {sh_ff[`ADCC_DATA_W-2:0], 1'b0};
      ser_out_ff <= sh_ff[`ADCC_DATA_W-2];
    end
  end

  assign bus_en = ~sync_ff[`ADCC_S_CS] & ~sync_ff[`ADCC_S_RD];
  assign PAR_DATA_O = sh_ff[12:0];
  assign PAR_DATA_OE = bus_en & ~serial_mode;
  assign SER_DATA_O = ser_out_ff;
  assign SER_DATA_OE = bus_en & serial_mode;
  assign D13_O = sh_ff[13];
  assign D14_O = sh_ff[14];
  assign D15_O = sh_ff[15];
  assign D13_OE = PAR_DATA_OE;
  assign D14_OE = PAR_DATA_OE;
  assign D15_OE = PAR_DATA_OE;
  assign BUSY = busy_ff;
  assign EFF_CFG = eff;
  assign CFG_REG = cfg_ff;
  assign RANGE_SEL = adcc_range_t'({eff.bipolar_sel, eff.wide_range_sel});

endmodule : adcc_top
`default_nettype wire

// ===== test/adcc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_checker
  import adcc_pkg::*;
#(
  parameter int BUSY_NS = 1000,
  parameter int BUSY_RAC_NS = 1500
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Pins
  input wire logic RESET_IN,
  input wire logic CFG_SOURCE_SELECT,
  input wire logic SERIAL_PARALLEL_SELECT,
  input wire logic WIDE_RANGE_SEL,
  input wire logic BIPOLAR_SEL,
  input wire logic D15_I,
  input wire logic CS_B,
  input wire logic RD_B,
  // Outputs watched
  input wire logic BUSY,
  input wire logic SER_DATA_OE,
  input wire logic D13_OE,
  input wire logic D14_OE,
  input wire logic D15_OE,
  input wire logic PAR_DATA_OE,
  input wire adcc_cfg_t EFF_CFG,
  input wire adcc_cfg_t CFG_REG,
  input wire adcc_range_t RANGE_SEL
);
  localparam int BC = BUSY_NS / 20;
  localparam int BRC = BUSY_RAC_NS / 20;
  int cnt_ff;
  logic abort_ff;
  logic rac;
  assign rac = SERIAL_PARALLEL_SELECT && !EFF_CFG.master_slave_select
    && !EFF_CFG.read_during_convert_sel;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cnt_ff <= 0;
      abort_ff <= 1'b0;
    end else begin
      cnt_ff <= BUSY ? cnt_ff + 1 : 0;
      abort_ff <= RESET_IN || (abort_ff && BUSY);
    end
  end
  sequence hw_steady;
    (CFG_SOURCE_SELECT && $stable({WIDE_RANGE_SEL, BIPOLAR_SEL})) [*4];
  endsequence
  chk_soft_source: assert property (
    (!CFG_SOURCE_SELECT) [*4] |-> EFF_CFG == CFG_REG)
    else $error("settings not from register");
  chk_hw_source: assert property (
    hw_steady |-> RANGE_SEL == {BIPOLAR_SEL, WIDE_RANGE_SEL})
    else $error("settings not from pins");
  chk_range_decode: assert property (
    RANGE_SEL == (EFF_CFG.bipolar_sel ?
      (EFF_CFG.wide_range_sel ? ADCC_BIP_10 : ADCC_BIP_5) :
      (EFF_CFG.wide_range_sel ? ADCC_UNI_10 : ADCC_UNI_5)))
    else $error("range decode wrong");
  chk_bus_gate: assert property (
    (CS_B || RD_B) [*3] |-> !PAR_DATA_OE && !SER_DATA_OE)
    else $error("bus enabled without select and read");
  chk_dpin_serial: assert property (
    SERIAL_PARALLEL_SELECT [*3] |-> !D13_OE && !D14_OE && !D15_OE)
    else $error("shared pins driven in serial mode");
  chk_reset_abort: assert property (RESET_IN [*4] |-> !BUSY)
    else $error("busy held during reset");
  chk_busy_len: assert property (
    $fell(BUSY) && !abort_ff |-> cnt_ff == (rac ? BRC : BC))
    else $error("busy length wrong");
  chk_cfg_hold: assert property (
    (D15_I && !RESET_IN) [*8] |-> $stable(CFG_REG))
    else $error("register changed while deselected");
endmodule : adcc_checker
bind adcc_top adcc_checker #(.BUSY_NS(BUSY_NS), .BUSY_RAC_NS(BUSY_RAC_NS)) adcc_checker_inst (
  .CLK_SYS,
  .RST_B,
  .RESET_IN,
  .CFG_SOURCE_SELECT,
  .SERIAL_PARALLEL_SELECT,
  .WIDE_RANGE_SEL,
  .BIPOLAR_SEL,
  .D15_I,
  .CS_B,
  .RD_B,
  .BUSY,
  .SER_DATA_OE,
  .D13_OE,
  .D14_OE,
  .D15_OE,
  .PAR_DATA_OE,
  .EFF_CFG,
  .CFG_REG,
  .RANGE_SEL
);
`default_nettype wire

// ===== test/adcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_host_model;
  logic sd = 1'b0;
  logic sck = 1'b0;
  logic scs_b = 1'b1;
  // Data flips after the active edge so a wrong edge choice samples garbage
  task automatic cfg_write(input logic [7:0] v, input int n, input logic inv);
    sck = inv;
    #80 scs_b = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sd = v[i];
      #80 sck = ~inv;
      #40 sd = ~v[i];
      #40 sck = inv;
    end
    #80 scs_b = 1'b1;
    #160;
  endtask : cfg_write
  task automatic stray(input int n);
    repeat (n) begin
      #80 sck = ~sck;
      sd = ~sd;
    end
  endtask : stray
endmodule : adcc_host_model
`default_nettype wire

// ===== test/test_adc_config_and_host_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_config_and_host_control
  import adcc_pkg::*;
;
  logic CLK_SYS = 1'b0, RST_B = 1'b0, RESET_IN = 1'b0, CONV_START = 1'b0, CS_B = 1'b1;
  logic RD_B = 1'b1, CFG_SOURCE_SELECT = 1'b1, SERIAL_PARALLEL_SELECT = 1'b0, SER_CLK_IN = 1'b0;
  logic MASTER_SLAVE_SELECT = 1'b0, READ_DURING_CONVERT_SEL = 1'b0, WIDE_RANGE_SEL = 1'b0;
  logic BIPOLAR_SEL = 1'b0, BINARY_FORMAT_SEL = 1'b1, CLK_EDGE_INVERT = 1'b0;
  logic [15:0] CONV_RESULT = 16'h0000;
  logic D13_O, D13_OE, D14_O, D14_OE, D15_O, D15_OE, PAR_DATA_OE, SER_DATA_O, SER_DATA_OE, BUSY;
  logic [12:0] PAR_DATA_O;
  adcc_cfg_t EFF_CFG, CFG_REG;
  adcc_range_t RANGE_SEL;
  int errors = 0, total_checks = 0;
  adcc_host_model adcc_host_model_inst ();
  wire logic D13_I = D13_OE ? D13_O : adcc_host_model_inst.sd;
  wire logic D14_I = D14_OE ? D14_O : adcc_host_model_inst.sck;
  wire logic D15_I = D15_OE ? D15_O : adcc_host_model_inst.scs_b;
  adcc_top #(.BUSY_NS(100), .BUSY_RAC_NS(200)) adcc_top_inst (.*);
  initial begin
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  task automatic step(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : step
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic give_up(input logic hit);
    if (hit) begin
      errors++;
      finish_test();
    end
  endtask : give_up
  task automatic conv(input logic [15:0] r, input int n);
    int c;
    c = 0;
    CONV_RESULT = r;
    CONV_START = 1'b1;
    while (BUSY !== 1'b1 && c < 20) begin
      step(1);
      c++;
    end
    give_up(c == 20);
    CONV_START = 1'b0;
    c = 0;
    while (BUSY === 1'b1 && c < 300) begin
      step(1);
      c++;
    end
    give_up(c == 300);
    check(16'(c), 16'(n));
  endtask : conv
  task automatic rd(input logic [15:0] e);
    CS_B = 1'b0;
    RD_B = 1'b0;
    step(3);
    check({PAR_DATA_OE, D13_OE, D14_OE, D15_OE}, 16'h000f);
    check({D15_O, D14_O, D13_O, PAR_DATA_O}, e);
    CS_B = 1'b1;
    RD_B = 1'b1;
    step(3);
    check(PAR_DATA_OE, 1'b0);
  endtask : rd
  task automatic ser_pulse();
    SER_CLK_IN = 1'b1;
    step(4);
    SER_CLK_IN = 1'b0;
    step(4);
  endtask : ser_pulse
  initial begin
    step(2);
    RST_B = 1'b1;
    step(5);
    check(CFG_REG, 5'h00);
    for (int i = 0; i < 4; i++) begin
      {BIPOLAR_SEL, WIDE_RANGE_SEL} = i[1:0];
      step(5);
      check(RANGE_SEL, i[1:0]);
    end
    SERIAL_PARALLEL_SELECT = 1'b1;
    CFG_SOURCE_SELECT = 1'b0;
    step(4);
    adcc_host_model_inst.cfg_write(8'h16, 5, 1'b0);
    step(6);
    check(CFG_REG, 5'h16);
    CLK_EDGE_INVERT = 1'b1;
    adcc_host_model_inst.cfg_write(8'h69, 7, 1'b1);
    step(6);
    check(CFG_REG, 5'h09);
    check(RANGE_SEL, 2'b01);
    // Deselected edges first: if counted, the short write below would commit
    adcc_host_model_inst.stray(8);
    adcc_host_model_inst.cfg_write(8'h07, 3, 1'b1);
    step(6);
    check(CFG_REG, 5'h09);
    SERIAL_PARALLEL_SELECT = 1'b0;
    CFG_SOURCE_SELECT = 1'b1;
    step(4);
    conv(16'ha5c3, 5);
    rd(16'ha5c3);
    BINARY_FORMAT_SEL = 1'b0;
    conv(16'h1234, 5);
    rd(16'h9234);
    SERIAL_PARALLEL_SELECT = 1'b1;
    step(4);
    conv(16'h0001, 10);
    READ_DURING_CONVERT_SEL = 1'b1;
    conv(16'h0002, 5);
    READ_DURING_CONVERT_SEL = 1'b0;
    MASTER_SLAVE_SELECT = 1'b1;
    conv(16'h0003, 5);
    // Slave serial read: clock ignored while chip select high
    ser_pulse();
    ser_pulse();
    check(SER_DATA_O, 1'b1);
    CS_B = 1'b0;
    RD_B = 1'b0;
    step(3);
    check({SER_DATA_OE, PAR_DATA_OE}, 16'h0002);
    for (int i = 15; i >= 0; i--) begin
      check(SER_DATA_O, (16'h8003 >> i) & 16'h0001);
      ser_pulse();
    end
    check(SER_DATA_O, 1'b0);
    CS_B = 1'b1;
    RD_B = 1'b1;
    MASTER_SLAVE_SELECT = 1'b0;
    step(4);
    CONV_START = 1'b1;
    step(6);
    check(BUSY, 1'b1);
    RESET_IN = 1'b1;
    step(4);
    check(BUSY, 1'b0);
    RESET_IN = 1'b0;
    CONV_START = 1'b0;
    SERIAL_PARALLEL_SELECT = 1'b0;
    BINARY_FORMAT_SEL = 1'b1;
    step(8);
    check(CFG_REG, 5'h00);
    rd(16'h0000);
    finish_test();
  end
endmodule : test_adc_config_and_host_control
`default_nettype wire
